//--- inc/ppg_regs.svh
`ifndef PPG_REGS_SVH
`define PPG_REGS_SVH

// register byte offsets
`define PPG_OFF_CTRL 12'h000
`define PPG_OFF_POL 12'h004
`define PPG_OFF_OE 12'h008
`define PPG_OFF_ODATA 12'h00C
`define PPG_OFF_TERM 12'h010
`define PPG_OFF_CNT 12'h014
`define PPG_OFF_BDATA 12'h018
`define PPG_OFF_STAT 12'h01C
`define PPG_OFF_ERR 12'h020
`define PPG_OFF_ISTAT 12'h024
`define PPG_OFF_IMASK 12'h028

// transfer control fields
`define PPG_CTRL_START 0
`define PPG_CTRL_WORD 1
`define PPG_CTRL_TERMINATOR_BYTE_CONDITION 2
`define PPG_CTRL_COUNT 3
`define PPG_CTRL_FLUSH 4

// output enable and polarity fields
`define PPG_OE_A 0
`define PPG_OE_B 1
`define PPG_POL_A 0
`define PPG_POL_B 1
`define PPG_POL_C 2
`define PPG_POL_D 3
`define PPG_OE_VAL_A 8'h01
`define PPG_OE_VAL_B 8'h02

// status fields
`define PPG_STAT_BUSY 0
`define PPG_STAT_EMPTY 1
`define PPG_STAT_FULL 2
`define PPG_STAT_SW4 3
`define PPG_STAT_LVL_LO 8
`define PPG_STAT_LVL_HI 14

// interrupt fields
`define PPG_IRQ_DONE 0
`define PPG_IRQ_FAIL 1

// reset values and count step
`define PPG_POL_RST 8'h00
`define PPG_TERM_RST 8'h0A
`define PPG_CNT_RST 16'h0000
`define PPG_CNT_ONE 16'h0001

// error codes
`define PPG_ERR_NONE 8'h00
`define PPG_ERR_ODD 8'h71
`define PPG_ERR_OE 8'h73
`define PPG_ERR_FULL 8'h7E

// receive buffer
`define PPG_BUF_DEPTH 64
`define PPG_BUF_FULL 7'h40

`endif

//--- inc/ppg_pkg.sv
package ppg_pkg;
    // one-hot receive transfer states
    typedef enum logic [4:0] {
        PPG_IDLE = 5'b00001,
        PPG_WAIT = 5'b00010,
        PPG_LO = 5'b00100,
        PPG_HI = 5'b01000,
        PPG_REL = 5'b10000
    } ppg_state_e;
    typedef logic [7:0] ppg_byte_t;
endpackage

//--- verilog/ppg_rx_buffer.sv
`timescale 1ns/1ps
`include "ppg_regs.svh"
module ppg_rx_buffer
    import ppg_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic push,
    input wire ppg_byte_t push_data,
    input wire logic pop,
    input wire logic flush,
    output ppg_byte_t rd_data,
    output logic [6:0] level,
    output logic full,
    output logic empty
);
    ppg_byte_t mem [0:`PPG_BUF_DEPTH-1];
    logic [5:0] wr_ptr_reg;
    logic [5:0] rd_ptr_reg;
    logic [6:0] level_reg;
    logic do_push;
    logic do_pop;

    // new bytes land behind the ones already held
    assign do_push = push & ~full;
    assign do_pop = pop & ~empty;
    assign full = (level_reg == `PPG_BUF_FULL);
    assign empty = (level_reg == 7'h00);
    assign level = level_reg;
    assign rd_data = mem[rd_ptr_reg];

    // storage array, no reset needed for data
    always_ff @(posedge pclk) begin
        if (do_push) begin
            mem[wr_ptr_reg] <= push_data;
        end
    end

    // pointers and fill level
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_ptr_reg <= 6'h00;
            rd_ptr_reg <= 6'h00;
            level_reg <= 7'h00;
        end else if (flush) begin
            wr_ptr_reg <= 6'h00;
            rd_ptr_reg <= 6'h00;
            level_reg <= 7'h00;
        end else begin
            wr_ptr_reg <= wr_ptr_reg + 6'(do_push);
            rd_ptr_reg <= rd_ptr_reg + 6'(do_pop);
            level_reg <= level_reg + 7'(do_push) - 7'(do_pop);
        end
    end

    property p_no_overfill;
        @(posedge pclk) disable iff (!presetn)
        (full && push && !pop && !flush) |=> full && $stable(wr_ptr_reg);
    endproperty
    a_no_overfill: assert property (p_no_overfill)
        else $error("buffer overwritten while full");
endmodule

//--- verilog/ppg_irq_ctrl.sv
`timescale 1ns/1ps
module ppg_irq_ctrl (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [1:0] set,
    input wire logic clr_we,
    input wire logic [1:0] clr_data,
    input wire logic mask_we,
    input wire logic [1:0] mask_data,
    output logic [1:0] status,
    output logic [1:0] mask,
    output logic irq
);
    logic [1:0] status_next;
    logic [1:0] mask_next;

    // write one to clear, a new event wins over the clear
    assign status_next = (status & ~(clr_we ? clr_data : 2'h0)) | set;
    assign mask_next = mask_we ? mask_data : mask;

    // sticky status, mask and registered level output
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status <= 2'h0;
            mask <= 2'h0;
            irq <= 1'b0;
        end else begin
            status <= status_next;
            mask <= mask_next;
            irq <= |(status_next & mask_next);
        end
    end

    property p_irq_level;
        @(posedge pclk) disable iff (!presetn)
        irq == |(status & mask);
    endproperty
    a_irq_level: assert property (p_irq_level)
        else $error("interrupt level does not follow status and mask");
endmodule

//--- verilog/ppg_top.sv
// What this block does
// - drivers of ports A and B stay off until that port's enable bit is set.
// - enable bits are only set while switch 4 is on, else code 115 is posted.
// - writing 2 to the output enable register turns on port B drivers.
// - the polarity register keeps one invert bit per port in bits 3..0.
// - an invert bit of one makes every data line of that port negative-true.
// - the polarity register reads back its whole current contents.
// - a word input takes low byte from port A and high byte from port B.
// - an odd byte count through the word port is refused with code 113.
// - interrupt transfers use the ordinary polarity and port settings.
// - a transfer ends on the terminator byte or a count, never an end line.
// - with terminator 10 the transfer stops after the line-feed byte, or in word mode after the word holding it.
// - with no terminator the transfer runs until the buffer is full.
// - data is appended to the buffer and overflow posts code 126.
`timescale 1ns/1ps
`include "ppg_regs.svh"
module ppg_top
    import ppg_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic cfg_switch4,
    input wire ppg_byte_t pa_in,
    output ppg_byte_t pa_out,
    output logic pa_oe_n,
    input wire ppg_byte_t pb_in,
    output ppg_byte_t pb_out,
    output logic pb_oe_n,
    output ppg_byte_t pc_out,
    output ppg_byte_t pd_out,
    input wire logic pa_flag,
    output logic pa_ctl,
    output logic irq
);
    ppg_state_e state_reg;
    logic [1:0] oe_en_reg;
    ppg_byte_t pol_reg;
    logic [31:0] odata_reg;
    ppg_byte_t term_reg;
    logic [15:0] cnt_reg;
    logic word_reg;
    logic terminator_byte_condition_en_reg;
    logic count_en_reg;
    ppg_byte_t err_code_reg;
    ppg_byte_t cap_a_reg;
    ppg_byte_t cap_b_reg;
    logic end_reg;
    logic done_pulse_reg;
    logic fail_pulse_reg;
    ppg_byte_t fail_code_reg;
    logic [31:0] rdata_next;
    logic hit;
    logic apb_setup;
    logic apb_done;
    logic wr;
    logic rd;
    logic busy;
    logic term_any;
    logic oe_refuse;
    logic start_w;
    logic flush_w;
    logic push;
    ppg_byte_t push_data;
    logic byte_hit;
    ppg_byte_t buf_rd;
    logic [6:0] buf_level;
    logic buf_full;
    logic buf_empty;
    logic [1:0] irq_status;
    logic [1:0] irq_mask;

    // bus phase decode
    assign apb_setup = psel & ~penable;
    assign apb_done = psel & penable & pready;
    assign wr = apb_done & pwrite;
    assign rd = apb_done & ~pwrite;
    assign busy = (state_reg != PPG_IDLE);
    assign term_any = terminator_byte_condition_en_reg | count_en_reg;

    // enable write carrying a set bit with the switch off is refused
    assign oe_refuse = wr & (paddr == `PPG_OFF_OE) & ~cfg_switch4
        & (pwdata[`PPG_OE_A] | pwdata[`PPG_OE_B]);
    assign start_w = wr & (paddr == `PPG_OFF_CTRL)
        & pwdata[`PPG_CTRL_START];
    assign flush_w = wr & (paddr == `PPG_OFF_CTRL)
        & pwdata[`PPG_CTRL_FLUSH];

    // read mux and address decode, sampled in the setup cycle
    always_comb begin
        rdata_next = '0;
        hit = 1'b1;
        case (paddr)
            `PPG_OFF_CTRL: begin
                rdata_next[`PPG_CTRL_WORD] = word_reg;
                rdata_next[`PPG_CTRL_TERMINATOR_BYTE_CONDITION] = terminator_byte_condition_en_reg;
                rdata_next[`PPG_CTRL_COUNT] = count_en_reg;
            end
            `PPG_OFF_POL: rdata_next[7:0] = pol_reg;
            `PPG_OFF_OE: rdata_next[1:0] = oe_en_reg;
            `PPG_OFF_ODATA: rdata_next = odata_reg;
            `PPG_OFF_TERM: rdata_next[7:0] = term_reg;
            `PPG_OFF_CNT: rdata_next[15:0] = cnt_reg;
            `PPG_OFF_BDATA: rdata_next[7:0] = buf_rd;
            `PPG_OFF_STAT: begin
                rdata_next[`PPG_STAT_BUSY] = busy;
                rdata_next[`PPG_STAT_EMPTY] = buf_empty;
                rdata_next[`PPG_STAT_FULL] = buf_full;
                rdata_next[`PPG_STAT_SW4] = cfg_switch4;
                rdata_next[`PPG_STAT_LVL_HI:`PPG_STAT_LVL_LO] = buf_level;
            end
            `PPG_OFF_ERR: rdata_next[7:0] = err_code_reg;
            `PPG_OFF_ISTAT: rdata_next[1:0] = irq_status;
            `PPG_OFF_IMASK: rdata_next[1:0] = irq_mask;
            default: hit = 1'b0;
        endcase
    end

    // bus answer: ready one cycle after setup, data and error registered
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= '0;
            pslverr <= 1'b0;
        end else begin
            pready <= apb_setup;
            if (apb_setup) begin
                prdata <= pwrite ? '0 : rdata_next;
                pslverr <= ~hit | (pwrite & (paddr == `PPG_OFF_OE)
                    & ~cfg_switch4 & (pwdata[`PPG_OE_A] | pwdata[`PPG_OE_B]));
            end
        end
    end

    // output enable register, only bits for ports A and B are kept
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            oe_en_reg <= 2'h0;
        end else if (wr && paddr == `PPG_OFF_OE && !oe_refuse) begin
            oe_en_reg <= pwdata[1:0];
        end
    end

    // polarity, output data and terminator byte
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pol_reg <= `PPG_POL_RST;
            odata_reg <= '0;
            term_reg <= `PPG_TERM_RST;
        end else if (wr) begin
            if (paddr == `PPG_OFF_POL) begin
                pol_reg <= pwdata[7:0];
            end
            if (paddr == `PPG_OFF_ODATA) begin
                odata_reg <= pwdata;
            end
            if (paddr == `PPG_OFF_TERM) begin
                term_reg <= pwdata[7:0];
            end
        end
    end

    // transfer mode bits, frozen while a transfer runs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            word_reg <= 1'b0;
            terminator_byte_condition_en_reg <= 1'b0;
            count_en_reg <= 1'b0;
        end else if (wr && paddr == `PPG_OFF_CTRL && !busy) begin
            word_reg <= pwdata[`PPG_CTRL_WORD];
            terminator_byte_condition_en_reg <= pwdata[`PPG_CTRL_TERMINATOR_BYTE_CONDITION];
            count_en_reg <= pwdata[`PPG_CTRL_COUNT];
        end
    end

    // port pins: polarity applied, drivers off unless enabled
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pa_out <= '0;
            pb_out <= '0;
            pc_out <= '0;
            pd_out <= '0;
            pa_oe_n <= 1'b1;
            pb_oe_n <= 1'b1;
        end else begin
            pa_out <= odata_reg[7:0] ^ {8{pol_reg[`PPG_POL_A]}};
            pb_out <= odata_reg[15:8] ^ {8{pol_reg[`PPG_POL_B]}};
            pc_out <= odata_reg[23:16] ^ {8{pol_reg[`PPG_POL_C]}};
            pd_out <= odata_reg[31:24] ^ {8{pol_reg[`PPG_POL_D]}};
            pa_oe_n <= ~(oe_en_reg[`PPG_OE_A] & ~busy);
            pb_oe_n <= ~(oe_en_reg[`PPG_OE_B] & ~(busy & word_reg));
        end
    end

    // byte pushed this cycle and its terminator test
    assign push = ((state_reg == PPG_LO) | (state_reg == PPG_HI))
        & ~buf_full;
    assign push_data = (state_reg == PPG_HI) ? cap_b_reg : cap_a_reg;
    assign byte_hit = (terminator_byte_condition_en_reg & (push_data == term_reg))
        | (count_en_reg & (cnt_reg == `PPG_CNT_ONE));

    // receive sequencer: handshake on port A lines, pairing, termination
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= PPG_IDLE;
            cnt_reg <= `PPG_CNT_RST;
            pa_ctl <= 1'b0;
            cap_a_reg <= '0;
            cap_b_reg <= '0;
            end_reg <= 1'b0;
            done_pulse_reg <= 1'b0;
            fail_pulse_reg <= 1'b0;
            fail_code_reg <= `PPG_ERR_NONE;
        end else begin
            done_pulse_reg <= 1'b0;
            fail_pulse_reg <= 1'b0;
            case (state_reg)
                PPG_IDLE: begin
                    pa_ctl <= 1'b0;
                    end_reg <= 1'b0;
                    if (wr && paddr == `PPG_OFF_CNT) begin
                        cnt_reg <= pwdata[15:0];
                    end
                    if (start_w) begin
                        if (pwdata[`PPG_CTRL_WORD] && pwdata[`PPG_CTRL_COUNT]
                            && cnt_reg[0]) begin
                            fail_pulse_reg <= 1'b1;
                            fail_code_reg <= `PPG_ERR_ODD;
                        end else if (buf_full && (pwdata[`PPG_CTRL_TERMINATOR_BYTE_CONDITION]
                            || pwdata[`PPG_CTRL_COUNT])) begin
                            fail_pulse_reg <= 1'b1;
                            fail_code_reg <= `PPG_ERR_FULL;
                        end else if (buf_full || (pwdata[`PPG_CTRL_COUNT]
                            && cnt_reg == `PPG_CNT_RST)) begin
                            done_pulse_reg <= 1'b1;
                        end else begin
                            state_reg <= PPG_WAIT;
                            pa_ctl <= 1'b1;
                        end
                    end
                end
                PPG_WAIT: begin
                    if (pa_flag) begin
                        cap_a_reg <= pa_in ^ {8{pol_reg[`PPG_POL_A]}};
                        cap_b_reg <= pb_in ^ {8{pol_reg[`PPG_POL_B]}};
                        pa_ctl <= 1'b0;
                        state_reg <= PPG_LO;
                    end
                end
                PPG_LO, PPG_HI: begin
                    if (buf_full) begin
                        state_reg <= PPG_IDLE;
                        if (term_any) begin
                            fail_pulse_reg <= 1'b1;
                            fail_code_reg <= `PPG_ERR_FULL;
                        end else begin
                            done_pulse_reg <= 1'b1;
                        end
                    end else begin
                        if (count_en_reg) begin
                            cnt_reg <= cnt_reg - `PPG_CNT_ONE;
                        end
                        end_reg <= end_reg | byte_hit;
                        if (state_reg == PPG_LO && word_reg) begin
                            state_reg <= PPG_HI;
                        end else begin
                            state_reg <= PPG_REL;
                        end
                    end
                end
                PPG_REL: begin
                    if (!pa_flag) begin
                        if (end_reg || (!term_any && buf_full)) begin
                            done_pulse_reg <= 1'b1;
                            state_reg <= PPG_IDLE;
                        end else begin
                            pa_ctl <= 1'b1;
                            state_reg <= PPG_WAIT;
                        end
                    end
                end
                default: begin
                    state_reg <= PPG_IDLE;
                    pa_ctl <= 1'b0;
                end
            endcase
        end
    end

    // last error code, refused enable write takes priority
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            err_code_reg <= `PPG_ERR_NONE;
        end else if (oe_refuse) begin
            err_code_reg <= `PPG_ERR_OE;
        end else if (fail_pulse_reg) begin
            err_code_reg <= fail_code_reg;
        end
    end

    ppg_rx_buffer u_buf (
        .pclk(pclk),
        .presetn(presetn),
        .push(push),
        .push_data(push_data),
        .pop(rd && paddr == `PPG_OFF_BDATA),
        .flush(flush_w),
        .rd_data(buf_rd),
        .level(buf_level),
        .full(buf_full),
        .empty(buf_empty)
    );

    ppg_irq_ctrl u_irq (
        .pclk(pclk),
        .presetn(presetn),
        .set({fail_pulse_reg | oe_refuse, done_pulse_reg}),
        .clr_we(wr && paddr == `PPG_OFF_ISTAT),
        .clr_data(pwdata[1:0]),
        .mask_we(wr && paddr == `PPG_OFF_IMASK),
        .mask_data(pwdata[1:0]),
        .status(irq_status),
        .mask(irq_mask),
        .irq(irq)
    );

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_oe_a_off;
        !oe_en_reg[`PPG_OE_A] |=> pa_oe_n;
    endproperty
    a_oe_a_off: assert property (p_oe_a_off)
        else $error("port A driven without enable");
    property p_oe_refuse;
        oe_refuse |=> $stable(oe_en_reg) && err_code_reg == `PPG_ERR_OE;
    endproperty
    a_oe_refuse: assert property (p_oe_refuse)
        else $error("enable write not refused with switch off");
    property p_oe_b;
        (wr && paddr == `PPG_OFF_OE && cfg_switch4 &&
            pwdata[7:0] == `PPG_OE_VAL_B) |=> oe_en_reg == 2'h2 ##1
            (pb_oe_n == (busy && word_reg));
    endproperty
    a_oe_b: assert property (p_oe_b)
        else $error("port B drivers not enabled by value 2");
    property p_oe_a;
        (wr && paddr == `PPG_OFF_OE && cfg_switch4 &&
            pwdata[1:0] == `PPG_OE_VAL_A) |=> oe_en_reg == 2'h1;
    endproperty
    a_oe_a: assert property (p_oe_a)
        else $error("port A enable not taken from bit 0");
    property p_in_invert;
        (state_reg == PPG_WAIT && pa_flag) |=> cap_a_reg ==
            ($past(pa_in) ^ {8{$past(pol_reg[`PPG_POL_A])}});
    endproperty
    a_in_invert: assert property (p_in_invert)
        else $error("port A input polarity wrong");
    property p_pol_read;
        (rd && paddr == `PPG_OFF_POL) |-> prdata[7:0] == pol_reg;
    endproperty
    a_pol_read: assert property (p_pol_read)
        else $error("polarity register read back wrong");
    property p_word_pair;
        (state_reg == PPG_LO && word_reg && !buf_full) |=>
            state_reg == PPG_HI ##1 state_reg != PPG_HI;
    endproperty
    a_word_pair: assert property (p_word_pair)
        else $error("word input not paired from ports A and B");
    property p_odd_refused;
        (start_w && !busy && pwdata[`PPG_CTRL_WORD] &&
            pwdata[`PPG_CTRL_COUNT] && cnt_reg[0]) |=>
            fail_pulse_reg && state_reg == PPG_IDLE ##1
            err_code_reg == `PPG_ERR_ODD;
    endproperty
    a_odd_refused: assert property (p_odd_refused)
        else $error("odd word count not refused");
    property p_terminator_byte_condition_end;
        (push && terminator_byte_condition_en_reg && push_data == term_reg) |=> end_reg;
    endproperty
    a_terminator_byte_condition_end: assert property (p_terminator_byte_condition_end)
        else $error("terminator byte did not end transfer");
    property p_overflow;
        ((state_reg == PPG_LO || state_reg == PPG_HI) && buf_full &&
            term_any) |=> fail_pulse_reg ##1 err_code_reg == `PPG_ERR_FULL;
    endproperty
    a_overflow: assert property (p_overflow)
        else $error("overflow code not posted");

    c_word_done: cover property (word_reg && done_pulse_reg);
    c_oe_refused: cover property (oe_refuse);
    c_terminator_byte_condition_done: cover property (terminator_byte_condition_en_reg && end_reg && done_pulse_reg);
    c_full_done: cover property (!term_any && done_pulse_reg && buf_full);
endmodule

//--- test/ppg_periph_model.sv
`timescale 1ns/1ps
module ppg_periph_model
    import ppg_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pa_ctl,
    input wire logic stall,
    input wire logic word,
    output logic pa_flag,
    output ppg_byte_t pa_in,
    output ppg_byte_t pb_in
);
    ppg_byte_t mem [0:255];
    ppg_byte_t idx;

    // default traffic never holds the line-feed code
    initial begin
        for (int i = 0; i < 256; i++) begin
            mem[i] = 8'h80 | 8'(i);
        end
    end

    // offer a unit once the device is ready, scramble lines once released
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pa_flag <= 1'b0;
            idx <= 8'h00;
            pa_in <= 8'h5A;
            pb_in <= 8'hA5;
        end else if (pa_ctl && !pa_flag && !stall) begin
            pa_flag <= 1'b1;
            pa_in <= mem[idx];
            pb_in <= mem[idx + 8'h01];
            idx <= idx + (word ? 8'h02 : 8'h01);
        end else if (!pa_ctl && pa_flag) begin
            pa_flag <= 1'b0;
            pa_in <= ~pa_in;
            pb_in <= ~pb_in;
        end
    end
endmodule

//--- test/ppg_top_tb.sv
`timescale 1ns/1ps
`include "ppg_regs.svh"
module ppg_top_tb
    import ppg_pkg::*;
;
    logic pclk;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic cfg_switch4 = 1'b0;
    logic stall = 1'b0;
    logic word = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rdat;
    logic pready, pslverr, serr, pa_oe_n, pb_oe_n, pa_flag, pa_ctl, irq;
    ppg_byte_t pa_in, pb_in, pa_out, pb_out, pc_out, pd_out, base;
    int errors = 0;
    int cmp_count = 0;
    int cycles = 0;

    ppg_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .cfg_switch4, .pa_in,
        .pa_out, .pa_oe_n, .pb_in, .pb_out, .pb_oe_n, .pc_out, .pd_out,
        .pa_flag, .pa_ctl, .irq);

    ppg_periph_model per (.pclk, .presetn, .pa_ctl, .stall, .word,
        .pa_flag, .pa_in, .pb_in);

    // 20 MHz clock
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    // hang guard
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errors++;
            stop_test();
        end
    end

    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one apb transfer, held until pready is sampled high
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdat = prdata;
        serr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // second edge lets registered pins catch up before any check
        repeat (2) @(posedge pclk);
    endtask

    // poll an interrupt status bit, then clear it
    task wait_ist(input int n);
        rdat = '0;
        while (rdat[n] !== 1'b1) apb(1'b0, `PPG_OFF_ISTAT, 32'h0);
        chk(irq, 32'h1);
        apb(1'b1, `PPG_OFF_ISTAT, 32'h1 << n);
    endtask

    task t_oe;
        chk({pa_oe_n, pb_oe_n}, 32'h3);
        apb(1'b0, `PPG_OFF_POL, 32'h0);
        chk(rdat, `PPG_POL_RST);
        apb(1'b0, 12'h030, 32'h0);
        chk(serr, 32'h1);
        chk(rdat, 32'h0);
        apb(1'b1, `PPG_OFF_OE, 32'h2);
        chk(serr, 32'h1);
        apb(1'b0, `PPG_OFF_ERR, 32'h0);
        chk(rdat, `PPG_ERR_OE);
        chk({pa_oe_n, pb_oe_n, irq}, 32'h6);
        apb(1'b1, `PPG_OFF_IMASK, 32'h3);
        apb(1'b0, `PPG_OFF_ISTAT, 32'h0);
        chk({irq, rdat[1:0]}, 32'h6);
        apb(1'b1, `PPG_OFF_ISTAT, 32'h2);
        apb(1'b0, `PPG_OFF_ISTAT, 32'h0);
        chk({irq, rdat[1:0]}, 32'h0);
        cfg_switch4 <= 1'b1;
        apb(1'b1, `PPG_OFF_OE, 32'h2);
        chk({serr, pa_oe_n, pb_oe_n}, 32'h2);
        apb(1'b1, `PPG_OFF_OE, 32'hFD);
        chk({pa_oe_n, pb_oe_n}, 32'h1);
        apb(1'b0, `PPG_OFF_OE, 32'h0);
        chk(rdat, 32'h1);
        $display("t_oe done");
    endtask

    task t_pol;
        apb(1'b1, `PPG_OFF_POL, 32'hA2);
        apb(1'b0, `PPG_OFF_POL, 32'h0);
        chk(rdat, 32'hA2);
        apb(1'b1, `PPG_OFF_POL, (rdat & 32'hF0) | 32'h5);
        apb(1'b0, `PPG_OFF_POL, 32'h0);
        chk(rdat, 32'hA5);
        apb(1'b1, `PPG_OFF_ODATA, 32'h1122_3344);
        chk({pd_out, pc_out, pb_out, pa_out}, 32'h11DD_33BB);
        $display("t_pol done");
    endtask

    task t_terminator_byte_condition;
        apb(1'b1, `PPG_OFF_POL, 32'h0);
        base = per.idx;
        per.mem[base] = 8'h41;
        per.mem[base + 8'h01] = 8'h0A;
        per.mem[base + 8'h02] = 8'h42;
        apb(1'b1, `PPG_OFF_CTRL, 32'h5);
        wait_ist(0);
        apb(1'b0, `PPG_OFF_STAT, 32'h0);
        chk(rdat[14:8], 32'h2);
        chk(per.idx, base + 8'h02);
        $display("t_terminator_byte_condition done");
    endtask

    task t_word;
        static logic [7:0] e [6] = '{8'h41, 8'h0A, 8'hED, 8'h34, 8'hA9,
            8'h78};
        apb(1'b1, `PPG_OFF_POL, 32'h1);
        base = per.idx;
        for (int i = 0; i < 4; i++) begin
            per.mem[base + 8'(i)] = 8'h12 + 8'(i) * 8'h22;
        end
        word <= 1'b1;
        stall <= 1'b1;
        apb(1'b1, `PPG_OFF_CNT, 32'h4);
        apb(1'b1, `PPG_OFF_CTRL, 32'hB);
        repeat (10) @(posedge pclk);
        chk(pa_ctl, 32'h1);
        stall <= 1'b0;
        wait_ist(0);
        apb(1'b0, `PPG_OFF_STAT, 32'h0);
        chk(rdat[14:8], 32'h6);
        for (int i = 0; i < 6; i++) begin
            apb(1'b0, `PPG_OFF_BDATA, 32'h0);
            chk(rdat, e[i]);
        end
        apb(1'b1, `PPG_OFF_CNT, 32'h3);
        apb(1'b1, `PPG_OFF_CTRL, 32'hB);
        wait_ist(1);
        apb(1'b0, `PPG_OFF_ERR, 32'h0);
        chk(rdat, `PPG_ERR_ODD);
        word <= 1'b0;
        $display("t_word done");
    endtask

    task t_fill;
        apb(1'b1, `PPG_OFF_CTRL, 32'h10);
        apb(1'b1, `PPG_OFF_CTRL, 32'h1);
        wait_ist(0);
        apb(1'b0, `PPG_OFF_STAT, 32'h0);
        chk({rdat[14:8], rdat[2]}, 32'h81);
        apb(1'b0, `PPG_OFF_ISTAT, 32'h0);
        chk(rdat, 32'h0);
        apb(1'b1, `PPG_OFF_CTRL, 32'h5);
        wait_ist(1);
        apb(1'b0, `PPG_OFF_ERR, 32'h0);
        chk(rdat, `PPG_ERR_FULL);
        apb(1'b1, `PPG_OFF_CTRL, 32'h10);
        apb(1'b0, `PPG_OFF_STAT, 32'h0);
        chk(rdat[1], 32'h1);
        $display("t_fill done");
    endtask

    task stop_test;
        $display("errors=%0d compares=%0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // reset, then every scenario in turn
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        t_oe();
        t_pol();
        t_terminator_byte_condition();
        t_word();
        t_fill();
        stop_test();
    end
endmodule
